// ==== crs_pkg.sv ====
// Package for the processor reset and power-up sequencing controller.
// Assumes a single 40 MHz bus-side clock; all counts are in those cycles.
`default_nettype none

package crs_pkg;

    // ---------------------------------------------------------------
    // Clock and time figures
    // ---------------------------------------------------------------
    localparam int CLK_MHZ            = 40;
    localparam int CLK_PERIOD_NS      = 25;
    localparam int RESET_HOLD_US      = 1000;
    localparam int RESET_HOLD_CYC     = RESET_HOLD_US * CLK_MHZ;
    localparam int CLK_WAIVE_NS       = 150;
    localparam int CLK_WAIVE_CYC      = (CLK_WAIVE_NS / CLK_PERIOD_NS < 1) ? 1 : CLK_WAIVE_NS / CLK_PERIOD_NS;

    // ---------------------------------------------------------------
    // Cycle counts from the bus timing
    // ---------------------------------------------------------------
    localparam int STRAP_SETUP_CYC    = 4;
    localparam int STRAP_HOLD_MIN_CYC = 2;
    localparam int STRAP_HOLD_MAX_CYC = 20;
    localparam int ACK_GAP_CYC        = 3;
    localparam int SLOW_PULSE_CYC     = 2;
    localparam int IRQ_EDGE_PULSE_CYC = 6;
    localparam int PWR_LOW_CYC        = 10;
    localparam int CLK_STABLE_CYC     = 10;

    // ---------------------------------------------------------------
    // Strap layout: address 14..5, bus request 0, purge, restart
    // ---------------------------------------------------------------
    localparam int STRAP_ADDR_W       = 10;
    localparam int STRAP_W            = 13;
    localparam int STRAP_BR0_BIT      = 10;
    localparam int STRAP_PURGE_BIT    = 11;
    localparam int STRAP_RESTART_BIT  = 12;
    localparam int RATIO_W            = 4;
    localparam logic [3:0] RATIO_MIN  = 4'h0;
    localparam logic [3:0] RATIO_MAX  = 4'h6;

    typedef enum logic [2:0] {
        CRS_OFF,
        CRS_CLK_WAIT,
        CRS_PWR_LOW,
        CRS_RST_HOLD,
        CRS_STRAP_SETUP,
        CRS_STRAP_HOLD,
        CRS_RUN
    } crs_state_t;

endpackage

`default_nettype wire

// ==== crs_pulse_gen.sv ====
// Minimum-width pulse stretcher for one slow input of the processor.
// Assumes requests are synchronous to clk; ce freezes the state.
`timescale 1ns/1ps
`default_nettype none

module crs_pulse_gen #(
    parameter int CNT_W = 4
) (
    input  wire logic             clk,       // Bus-side clock.
    input  wire logic             resetn,    // Asynchronous reset, active low.
    input  wire logic             ce,        // Clock enable.
    input  wire logic             req,       // Requested level.
    input  wire logic [CNT_W-1:0] min_cyc,   // Least cycles in each state.
    output logic                  pin_out    // Level driven to the pin.
);

    logic             lvl_reg;
    logic             lvl_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    // A level change is taken only once the present level has stood its minimum.
    always_comb
    begin
        lvl_next = lvl_reg;
        cnt_next = cnt_reg;
        if (cnt_reg != '0)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
        else if (req != lvl_reg)
        begin
            lvl_next = req;
            cnt_next = min_cyc - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lvl_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else if (ce)
        begin
            lvl_reg <= lvl_next;
            cnt_reg <= cnt_next;
        end
    end

    assign pin_out = lvl_reg;

endmodule

`default_nettype wire

// ==== crs_sequencer.sv ====
// Reset and power-up sequencing controller that drives a processor's reset,
// power-good, straps, slow inputs, local interrupt pins and target-ready.
// Assumes supply and clock status inputs are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Reset asserts at any time; release happens only on a clock edge; reset_req asserts reset in CRS_RUN with ce high, at the next edge, and stalls release.
// - Reset held at least 1.00 ms after supply and clock are stable.
// - Straps driven to final values at least 4 clocks before release.
// - Straps kept stable 2 clocks after release, released by 20.
// - At least 3 clocks between two active-to-inactive target-ready edges.
// - Every slow input except power-good holds each state at least 2 clocks.
// - Local interrupt pins pulse 6 clocks when controller on and edge-triggered fixed delivery.
// - Power-good stays inactive at least 10 clocks each time it drops.
// - Power-good waits for supplies good and 10 stable clock cycles; with fast_clk_start the code skips the stable-clock wait.
// - A clock stable within 150 ns waives the inactive minimum.
// - Only listed core-to-bus ratios may be selected; ratio_sel is checked only as power-good rises, not at a later reset request.
// - Ratio fixed at initialisation; multipliers 4 to 7 in half steps.
module crs_sequencer #(
    parameter int RESET_HOLD_CYC = crs_pkg::RESET_HOLD_CYC,
    parameter int SLOW_N         = 2
) (
    input  wire logic                          clk,             // Bus-side clock.
    input  wire logic                          resetn,          // Asynchronous reset, active low.
    input  wire logic                          ce,              // Clock enable.
    input  wire logic                          core_supply_ok,  // Core supply in tolerance.
    input  wire logic                          all_supply_ok,   // All supplies in tolerance.
    input  wire logic                          bus_clk_ok,      // Bus clock within specification.
    input  wire logic                          fast_clk_start,  // Clock settles within 150 ns.
    input  wire logic                          reset_req,       // Request processor reset.
    input  wire logic [crs_pkg::STRAP_ADDR_W-1:0] strap_addr,   // Address strap values.
    input  wire logic                          strap_br0,       // Bus request 0 strap value.
    input  wire logic                          strap_purge,     // Cache purge strap value.
    input  wire logic                          strap_restart,   // Warm restart strap value.
    input  wire logic [crs_pkg::RATIO_W-1:0]   ratio_sel,       // Multiplier code, 0 = x4 in half steps.
    input  wire logic [SLOW_N-1:0]             slow_req,        // Requested slow input levels.
    input  wire logic [1:0]                    irq_req,         // Requested local interrupt levels.
    input  wire logic                          irq_ctrl_on,     // Local interrupt controller enabled.
    input  wire logic [1:0]                    irq_edge_fixed,  // Pin set to edge-triggered fixed.
    input  wire logic                          ack_req,         // Requested target-ready, active high.
    output logic                               cpu_reset_n,     // Processor reset, active low.
    output logic                               power_ok_in,     // Power-good to the processor.
    output logic [crs_pkg::STRAP_W-1:0]        strap_out,       // Strap levels.
    output logic                               strap_oe,        // Straps driven.
    output logic [crs_pkg::RATIO_W-1:0]        ratio_out,       // Latched ratio code.
    output logic [SLOW_N-1:0]                  slow_out,        // Slow input pins.
    output logic [1:0]                         local_irq_pins,  // Local interrupt pins.
    output logic                               target_ack_n,    // Target-ready, active low.
    output logic                               ratio_bad,       // Requested ratio unsupported.
    output logic                               running          // Processor out of reset.
);

    localparam int CNT_W = $clog2(RESET_HOLD_CYC + 1) + 1;

    crs_pkg::crs_state_t           st_reg;
    crs_pkg::crs_state_t           st_next;
    logic [CNT_W-1:0]              cnt_reg;
    logic [CNT_W-1:0]              cnt_next;
    logic [crs_pkg::STRAP_W-1:0]   strap_reg;
    logic [crs_pkg::STRAP_W-1:0]   strap_next;
    logic                          oe_reg;
    logic                          oe_next;
    logic [crs_pkg::RATIO_W-1:0]   ratio_reg;
    logic [crs_pkg::RATIO_W-1:0]   ratio_next;
    logic                          rst_reg;
    logic                          rst_next;
    logic                          pg_reg;
    logic                          pg_next;
    logic                          ack_reg;
    logic                          ack_next;
    logic [1:0]                    gap_reg;
    logic [1:0]                    gap_next;
    logic                          ratio_ok;
    logic                          power_ok;

    assign ratio_ok = (ratio_sel - crs_pkg::RATIO_MIN) <= (crs_pkg::RATIO_MAX - crs_pkg::RATIO_MIN);
    assign power_ok = core_supply_ok && all_supply_ok && bus_clk_ok;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        strap_next = strap_reg;
        oe_next    = oe_reg;
        ratio_next = ratio_reg;
        rst_next   = rst_reg;
        pg_next    = pg_reg;
        case (st_reg)
            crs_pkg::CRS_OFF:
            begin
                if (core_supply_ok && bus_clk_ok)
                begin
                    st_next  = crs_pkg::CRS_CLK_WAIT;
                    cnt_next = CNT_W'(crs_pkg::CLK_STABLE_CYC - 1);
                end
            end
            crs_pkg::CRS_CLK_WAIT:
            begin
                // Count stable clock cycles; a fast-starting clock skips the wait.
                if (!bus_clk_ok && !fast_clk_start)
                    cnt_next = CNT_W'(crs_pkg::CLK_STABLE_CYC - 1);
                else if (cnt_reg != '0 && !fast_clk_start)
                    cnt_next = cnt_reg - 1'b1;
                else
                begin
                    st_next  = crs_pkg::CRS_PWR_LOW;
                    cnt_next = fast_clk_start ? '0 : CNT_W'(crs_pkg::PWR_LOW_CYC - 1);
                end
            end
            crs_pkg::CRS_PWR_LOW:
            begin
                // A clock dropout restarts the count unless fast_clk_start is set, so only a fast-starting clock lets power-good follow a short run of clocks.
                if (!bus_clk_ok && !fast_clk_start)
                begin
                    st_next  = crs_pkg::CRS_CLK_WAIT;
                    cnt_next = CNT_W'(crs_pkg::CLK_STABLE_CYC - 1);
                end
                else if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else if (power_ok && ratio_ok)
                begin
                    pg_next  = 1'b1;
                    st_next  = crs_pkg::CRS_RST_HOLD;
                    cnt_next = CNT_W'(RESET_HOLD_CYC - 1);
                end
            end
            crs_pkg::CRS_RST_HOLD:
            begin
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else if (!reset_req)
                begin
                    // Straps and ratio are frozen here for the whole release window.
                    strap_next = {strap_restart, strap_purge, strap_br0, strap_addr};
                    ratio_next = ratio_sel;
                    oe_next    = 1'b1;
                    st_next    = crs_pkg::CRS_STRAP_SETUP;
                    cnt_next   = CNT_W'(crs_pkg::STRAP_SETUP_CYC - 1);
                end
            end
            crs_pkg::CRS_STRAP_SETUP:
            begin
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else
                begin
                    rst_next = 1'b1;
                    st_next  = crs_pkg::CRS_STRAP_HOLD;
                    cnt_next = CNT_W'(crs_pkg::STRAP_HOLD_MIN_CYC);
                end
            end
            crs_pkg::CRS_STRAP_HOLD:
            begin
                // Hold one edge past the minimum, well short of the 20-clock limit.
                if (cnt_reg != '0)
                    cnt_next = cnt_reg - 1'b1;
                else
                begin
                    oe_next = 1'b0;
                    st_next = crs_pkg::CRS_RUN;
                end
            end
            crs_pkg::CRS_RUN:
            begin
                if (reset_req)
                begin
                    rst_next = 1'b0;
                    st_next  = crs_pkg::CRS_RST_HOLD;
                    cnt_next = CNT_W'(RESET_HOLD_CYC - 1);
                end
            end
            default:
            begin
                st_next = crs_pkg::CRS_OFF;
            end
        endcase
        // Loss of power drops power-good and reset at once, on any state.
        if (!core_supply_ok || !all_supply_ok)
        begin
            st_next  = crs_pkg::CRS_OFF;
            pg_next  = 1'b0;
            rst_next = 1'b0;
            oe_next  = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg    <= crs_pkg::CRS_OFF;
            cnt_reg   <= '0;
            strap_reg <= '0;
            oe_reg    <= 1'b0;
            ratio_reg <= crs_pkg::RATIO_MIN;
            rst_reg   <= 1'b0;
            pg_reg    <= 1'b0;
        end
        else if (ce)
        begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            strap_reg <= strap_next;
            oe_reg    <= oe_next;
            ratio_reg <= ratio_next;
            rst_reg   <= rst_next;
            pg_reg    <= pg_next;
        end
    end

    // ---------------------------------------------------------------
    // Target-ready spacing
    // ---------------------------------------------------------------
    always_comb
    begin
        ack_next = ack_reg;
        gap_next = (gap_reg != 2'h0) ? gap_reg - 2'h1 : 2'h0;
        if (ack_req && !ack_reg)
            ack_next = 1'b1;
        else if (!ack_req && ack_reg && gap_reg == 2'h0)
        begin
            ack_next = 1'b0;
            gap_next = 2'(crs_pkg::ACK_GAP_CYC - 1);
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_reg <= 1'b0;
            gap_reg <= 2'h0;
        end
        else if (ce)
        begin
            ack_reg <= ack_next;
            gap_reg <= gap_next;
        end
    end

    // ---------------------------------------------------------------
    // Slow inputs and local interrupt pins
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < SLOW_N + 2; gi++)
        begin : g_pulse
            logic       req_i;
            logic [3:0] min_i;
            logic       out_i;
            if (gi < SLOW_N)
            begin : g_slow
                assign req_i = slow_req[gi];
                assign min_i = 4'(crs_pkg::SLOW_PULSE_CYC);
                assign slow_out[gi] = out_i;
            end
            else
            begin : g_irq
                assign req_i = irq_req[gi-SLOW_N];
                assign min_i = (irq_ctrl_on && irq_edge_fixed[gi-SLOW_N]) ?
                               4'(crs_pkg::IRQ_EDGE_PULSE_CYC) : 4'(crs_pkg::SLOW_PULSE_CYC);
                assign local_irq_pins[gi-SLOW_N] = out_i;
            end
            crs_pulse_gen #(.CNT_W(4)) u_pulse (
                .clk     (clk),
                .resetn  (resetn),
                .ce      (ce),
                .req     (req_i),
                .min_cyc (min_i),
                .pin_out (out_i)
            );
        end
    endgenerate

    assign cpu_reset_n  = rst_reg;
    assign power_ok_in  = pg_reg;
    assign strap_out    = strap_reg;
    assign strap_oe     = oe_reg;
    assign ratio_out    = ratio_reg;
    assign target_ack_n = ~ack_reg;
    assign ratio_bad    = ~ratio_ok;
    assign running      = (st_reg == crs_pkg::CRS_RUN);

endmodule

`default_nettype wire

// ==== crs_seq_properties.sv ====
// Concurrent checks on the pin timing of the reset sequencer.
// Assumes it is bound to crs_sequencer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module crs_seq_props #(
    parameter int RESET_HOLD_CYC = 20,
    parameter int SLOW_N = 2
) (
    input wire logic clk, // Bus clock.
    input wire logic resetn, // Reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic all_supply_ok, // Supplies good.
    input wire logic bus_clk_ok, // Clock good.
    input wire logic fast_clk_start, // Fast clock start.
    input wire logic reset_req, // Reset request.
    input wire logic [crs_pkg::RATIO_W-1:0] ratio_sel, // Ratio code.
    input wire logic irq_ctrl_on, // Interrupt controller on.
    input wire logic [1:0] irq_edge_fixed, // Edge-fixed pins.
    input wire logic cpu_reset_n, // Processor reset.
    input wire logic power_ok_in, // Power-good.
    input wire logic [crs_pkg::STRAP_W-1:0] strap_out, // Straps.
    input wire logic strap_oe, // Straps driven.
    input wire logic [SLOW_N-1:0] slow_out, // Slow pins.
    input wire logic [1:0] local_irq_pins, // Interrupt pins.
    input wire logic target_ack_n, // Target-ready.
    input wire logic running // Out of reset.
);
    // ---
    // Cycle counters
    // ---
    logic [7:0] lo_reg, lo_next, ok_reg, ok_next, gp_reg, gp_next;
    logic [15:0] hd_reg, hd_next;
    logic ak_reg;

    // The counters saturate so that a long idle stretch never wraps into a false short gap.
    always_comb
    begin
        lo_next = power_ok_in ? 8'h00 : lo_reg + {7'h00, lo_reg != 8'hFF};
        ok_next = (all_supply_ok && bus_clk_ok) ? ok_reg + {7'h00, ok_reg != 8'hFF} : 8'h00;
        hd_next = (power_ok_in && !cpu_reset_n) ? hd_reg + {15'h0000, hd_reg != 16'hFFFF} : 16'h0000;
        gp_next = (target_ack_n && !ak_reg) ? 8'h01 : gp_reg + {7'h00, gp_reg != 8'hFF};
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lo_reg <= 8'h00;
            ok_reg <= 8'h00;
            hd_reg <= 16'h0000;
            gp_reg <= 8'hFF;
            ak_reg <= 1'b1;
        end
        else
        begin
            lo_reg <= lo_next;
            ok_reg <= ok_next;
            hd_reg <= hd_next;
            gp_reg <= gp_next;
            ak_reg <= target_ack_n;
        end
    end

    // ---
    // Properties
    // ---
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_rst_req; running && ce && reset_req |-> ##[1:2] !cpu_reset_n; endproperty
    a_rst_req: assert property (p_rst_req) else $error("reset not applied");
    property p_rst_hold; $rose(cpu_reset_n) |-> hd_reg >= RESET_HOLD_CYC; endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset released early");
    property p_strap_setup; $rose(cpu_reset_n) |-> $past(strap_oe, 4) && $past(strap_out, 4) == strap_out; endproperty
    a_strap_setup: assert property (p_strap_setup) else $error("straps set late");
    property p_strap_hold; $rose(cpu_reset_n) |=> (strap_oe && $stable(strap_out))[*2] ##[1:18] !strap_oe; endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap hold wrong");
    property p_ack_gap; $rose(target_ack_n) |-> gp_reg >= 3; endproperty
    a_ack_gap: assert property (p_ack_gap) else $error("target-ready gap short");
    property p_slow_min; $changed(slow_out[0]) |=> $stable(slow_out[0]); endproperty
    a_slow_min: assert property (p_slow_min) else $error("slow pin pulse short");
    property p_irq_pulse; $rose(local_irq_pins[0]) && irq_ctrl_on && irq_edge_fixed[0] |=> local_irq_pins[0][*5]; endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse short");
    property p_pwr_low; $rose(power_ok_in) && !fast_clk_start |-> lo_reg >= 10; endproperty
    a_pwr_low: assert property (p_pwr_low) else $error("power-good low too short");
    property p_pwr_wait; $rose(power_ok_in) |-> $past(all_supply_ok) && (fast_clk_start || ok_reg >= 10); endproperty
    a_pwr_wait: assert property (p_pwr_wait) else $error("power-good too early");
    property p_ratio; $rose(power_ok_in) |-> $past(ratio_sel) <= 4'h6; endproperty
    a_ratio: assert property (p_ratio) else $error("unsupported ratio started");
endmodule
`default_nettype wire

// ==== crs_cpu_model.sv ====
// Behavioural model of the processor pins that the sequencer drives.
// Assumes it shares the bus clock with the sequencer.
`timescale 1ns/1ps
`default_nettype none
module crs_cpu_model (
    input wire logic clk, // Bus clock.
    input wire logic cpu_reset_n, // Reset, active low.
    input wire logic [crs_pkg::STRAP_W-1:0] strap_out, // Strap levels.
    input wire logic strap_oe, // Straps driven.
    input wire logic [crs_pkg::RATIO_W-1:0] ratio_out, // Ratio code.
    input wire logic [1:0] slow_out, // Slow pins.
    input wire logic [1:0] local_irq_pins, // Interrupt pins.
    output logic [crs_pkg::STRAP_W-1:0] cfg, // Latched configuration.
    output logic [crs_pkg::RATIO_W-1:0] core_ratio, // Latched ratio.
    output logic [3:0] slow_sync // Synchronised slow and interrupt pins.
);
    logic rst_q = 1'b0;
    logic [3:0] s1;

    always_ff @(posedge clk)
    begin
        s1 <= {local_irq_pins, slow_out};
        slow_sync <= s1;
        rst_q <= cpu_reset_n;
        if (cpu_reset_n && !rst_q)
        begin
            // Undriven straps read back inverted so a released bus never passes by luck.
            cfg <= strap_oe ? strap_out : ~strap_out;
            core_ratio <= ratio_out;
        end
    end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the reset and power-up sequencer.
// Assumes the checker and the processor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int HOLD = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic sup = 1'b0;
    logic fast = 1'b0;
    logic reset_req = 1'b0;
    logic ack_req = 1'b0;
    logic irq_ctrl_on = 1'b0;
    logic [1:0] irq_edge_fixed = 2'h0;
    logic [1:0] slow_req = 2'h0;
    logic [1:0] irq_req = 2'h0;
    logic [3:0] ratio_sel = 4'h0;
    logic [12:0] sv = 13'h0000;
    logic cpu_reset_n, power_ok_in, strap_oe, ratio_bad, running, target_ack_n;
    logic [12:0] strap_out, cfg;
    logic [3:0] ratio_out, core_ratio, sy;
    logic [1:0] slow_out, local_irq_pins;
    int fails = 0;
    int total_checks = 0;
    // Rows: pin watched, controller on, edge-fixed, exact width expected.
    int row_pin[5] = '{3, 4, 5, 5, 5};
    logic row_on[5] = '{0, 0, 1, 1, 0};
    logic row_ef[5] = '{0, 0, 1, 0, 1};
    int row_w[5] = '{2, 2, 6, 2, 2};

    always #12.5 clk = ~clk;

    crs_sequencer #(.RESET_HOLD_CYC(HOLD), .SLOW_N(2)) dut (
        .clk, .resetn, .ce, .core_supply_ok(sup), .all_supply_ok(sup), .bus_clk_ok(sup),
        .fast_clk_start(fast), .reset_req, .strap_addr(sv[9:0]), .strap_br0(sv[10]),
        .strap_purge(sv[11]), .strap_restart(sv[12]), .ratio_sel, .slow_req, .irq_req,
        .irq_ctrl_on, .irq_edge_fixed, .ack_req, .cpu_reset_n, .power_ok_in, .strap_out,
        .strap_oe, .ratio_out, .slow_out, .local_irq_pins, .target_ack_n, .ratio_bad, .running
    );
    crs_cpu_model cpu (
        .clk, .cpu_reset_n, .strap_out, .strap_oe, .ratio_out, .slow_out, .local_irq_pins,
        .cfg, .core_ratio, .slow_sync(sy)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Inputs change and outputs are read on falling edges, clear of the sampling edge.
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    function automatic logic sig(input int s);
        case (s)
            0: return power_ok_in;
            1: return cpu_reset_n;
            2: return !power_ok_in;
            3: return slow_out[0];
            4: return slow_out[1];
            default: return local_irq_pins[0];
        endcase
    endfunction

    task automatic wt(input int s, output int n);
        n = 0;
        while (sig(s) !== 1'b1 && n < 200)
        begin
            cyc(1);
            n++;
        end
    endtask

    task automatic up(input logic [3:0] r, input logic f, output int np, output int nr);
        sup = 1'b0;
        cyc(12);
        ratio_sel = r;
        fast = f;
        sv = 13'h1A5C ^ {9'h000, r};
        sup = 1'b1;
        wt(0, np);
        wt(1, nr);
    endtask

    initial
    begin
        int i, k, n, np, nr, w, g, last;
        logic pa;
        cyc(12);
        resetn = 1'b1;
        chk({cpu_reset_n, power_ok_in, strap_oe, target_ack_n, running}, 5'b00010);
        up(4'h0, 1'b0, np, nr);
        for (i = 0; i < 5; i++)
        begin
            irq_ctrl_on = row_on[i];
            irq_edge_fixed = {2{row_ef[i]}};
            cyc(8);
            slow_req = {row_pin[i] == 4, row_pin[i] == 3};
            irq_req = {1'b0, row_pin[i] == 5};
            cyc(1);
            slow_req = 2'h0;
            irq_req = 2'h0;
            w = 0;
            for (k = 0; k < 30; k++)
            begin
                // Sample before stepping, so the cycle in which the pin first rises is counted.
                w += sig(row_pin[i]);
                cyc(1);
            end
            chk(w, row_w[i]);
        end
        chk(sy, 4'h0);
        for (i = 0; i < 8; i++)
        begin
            up(i[3:0], 1'b0, np, nr);
            chk(ratio_bad, i > 6);
            chk(power_ok_in, i < 7);
            if (i < 7)
            begin
                chk(np >= 20, 1);
                chk(nr >= HOLD + 4, 1);
                cyc(4);
                chk(cfg, sv);
                chk(core_ratio, i[3:0]);
            end
        end
        up(4'h3, 1'b0, np, nr);
        cyc(4);
        reset_req = 1'b1;
        cyc(2);
        chk(cpu_reset_n, 0);
        reset_req = 1'b0;
        wt(1, n);
        chk(n >= HOLD, 1);
        cyc(4);
        pa = target_ack_n;
        last = -1;
        g = 99;
        for (k = 0; k < 30; k++)
        begin
            ack_req = k < 6 && !k[0];
            cyc(1);
            if (target_ack_n && !pa)
            begin
                if (last >= 0 && k - last < g)
                    g = k - last;
                last = k;
            end
            pa = target_ack_n;
        end
        chk(g >= 3 && g < 99, 1);
        sup = 1'b0;
        cyc(1);
        sup = 1'b1;
        wt(2, n);
        wt(0, n);
        chk(n >= 10, 1);
        up(4'h6, 1'b1, np, nr);
        chk(np < 20 && power_ok_in, 1);
        cyc(4);
        ce = 1'b0;
        reset_req = 1'b1;
        cyc(4);
        chk({cpu_reset_n, running}, 2'h3);
        ce = 1'b1;
        cyc(2);
        chk(cpu_reset_n, 0);
        reset_req = 1'b0;
        resetn = 1'b0;
        cyc(2);
        chk({cpu_reset_n, power_ok_in, strap_oe, target_ack_n, running}, 5'b00010);
        resetn = 1'b1;
        wt(0, n);
        chk(n < 20 && power_ok_in, 1);
        close_out();
    end

    // The whole sequence needs well under 2000 cycles; this margin only catches a hang.
    initial
    begin
        cyc(20000);
        fails++;
        close_out();
    end
endmodule

bind crs_sequencer crs_seq_props #(.RESET_HOLD_CYC(RESET_HOLD_CYC), .SLOW_N(SLOW_N)) u_props (
    .clk, .resetn, .ce, .all_supply_ok, .bus_clk_ok, .fast_clk_start, .reset_req, .ratio_sel,
    .irq_ctrl_on, .irq_edge_fixed, .cpu_reset_n, .power_ok_in, .strap_out, .strap_oe,
    .slow_out, .local_irq_pins, .target_ack_n, .running
);
`default_nettype wire
